// [lnmc_defs.svh]
`ifndef LNMC_DEFS_SVH
`define LNMC_DEFS_SVH

// Base tick period in ns and clock period in ns
`define LNMC_CLK_NS          5
`define LNMC_TICK_NS         1000
`define LNMC_TICK_CYC        (`LNMC_TICK_NS / `LNMC_CLK_NS)
// Durations in microseconds, counted in ticks of 1 us
`define LNMC_WAKE_LOW_US     70
`define LNMC_CS_FILT_US      10
`define LNMC_DOM_TIMEOUT_US  25000
// Supply stabilisation delay in ticks
`define LNMC_SUPPLY_US       1

`endif

// [lnmc_pkg.sv]
package lnmc_pkg;
    typedef enum logic [2:0] {
        LNMC_POR,
        LNMC_READY,
        LNMC_OPERATION,
        LNMC_TX_OFF,
        LNMC_POWERDOWN
    } lnmc_mode_t;
endpackage : lnmc_pkg

// [lnmc_sync.sv]
`timescale 1ns/100ps
// Two flip-flop synchroniser for asynchronous pin levels
module lnmc_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            meta_reg <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : lnmc_sync

// [lnmc_filter.sv]
`timescale 1ns/100ps
// Level filter: output follows input only after it stays stable for HOLD ticks
module lnmc_filter #(
    parameter int HOLD = 10
) (
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic tick,
    input  wire logic din,
    output logic      dout
);
    logic [15:0] cnt_reg;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cnt_reg <= 16'h0000;
            dout    <= 1'b0;
        end else if (din == dout) begin
            cnt_reg <= 16'h0000;
        end else if (tick) begin
            if (cnt_reg >= 16'(HOLD - 1)) begin
                dout    <= din;
                cnt_reg <= 16'h0000;
            end else begin
                cnt_reg <= cnt_reg + 16'h0001;
            end
        end
    end
endmodule : lnmc_filter

// [lnmc_top.sv]
`timescale 1ns/100ps
`include "lnmc_defs.svh"
module lnmc_top #(
    parameter int TICK_CYC    = `LNMC_TICK_CYC,
    parameter int WAKE_LOW    = `LNMC_WAKE_LOW_US,
    parameter int CS_FILT     = `LNMC_CS_FILT_US,
    parameter int DOM_TIMEOUT = `LNMC_DOM_TIMEOUT_US
) (
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic supply_ok,
    input  wire logic over_temp,
    input  wire logic chip_select,
    input  wire logic wake_n,
    input  wire logic txd,
    input  wire logic bus_in,
    input  wire logic rxd_line,
    output logic      bus_out,
    output logic      bus_oe,
    output logic      rxd_out,
    output logic      rxd_oe,
    output logic      strong_bus_pullup,
    output logic      regulator_enable_out,
    output logic      transmitter_off_state
);
    logic [4:0] pin_sync;
    logic       cs_s;
    logic       wake_s;
    logic       txd_s;
    logic       bus_s;
    logic       rxl_s;
    logic       cs_f;
    logic       cs_prev_reg;
    logic       wake_prev_reg;
    logic       txd_prev_reg;
    logic       bus_prev_reg;
    logic       cs_fall;
    logic       wake_fall;
    logic       txd_rise;
    logic       bus_rise;
    logic [15:0] tick_cnt_reg;
    logic        tick;
    logic [15:0] wake_cnt_reg;
    logic        wake_long_reg;
    logic [15:0] txd_dom_cnt_reg;
    logic        txd_to_reg;
    logic [15:0] bus_dom_cnt_reg;
    logic        bus_to_reg;
    logic        rx_mon_fault_reg;
    logic [1:0]  rx_rel_cnt_reg;
    logic        fault;
    logic        tx_active;
    lnmc_pkg::lnmc_mode_t mode_reg;
    lnmc_pkg::lnmc_mode_t mode_next;

    // Idle-high pins reset to their idle level so no false edge follows reset
    lnmc_sync #(
        .WIDTH  (5),
        .RST_VAL(5'h0F)
    ) u_sync (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .async_in({chip_select, wake_n, txd, bus_in, rxd_line}),
        .sync_out(pin_sync)
    );

    assign cs_s   = pin_sync[4];
    assign wake_s = pin_sync[3];
    assign txd_s  = pin_sync[2];
    assign bus_s  = pin_sync[1];
    assign rxl_s  = pin_sync[0];

    // True in the modes that power the regulator and the receiver
    function automatic logic mode_powered(input lnmc_pkg::lnmc_mode_t m);
        return (m != lnmc_pkg::LNMC_POWERDOWN) && (m != lnmc_pkg::LNMC_POR);
    endfunction : mode_powered

    // Tick divider
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            tick_cnt_reg <= 16'h0000;
        end else if (tick) begin
            tick_cnt_reg <= 16'h0000;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 16'h0001;
        end
    end
    assign tick = (tick_cnt_reg >= 16'(TICK_CYC - 1));

    // Mode-select glitch filter, reset low
    lnmc_filter #(
        .HOLD(CS_FILT)
    ) u_cs_filt (
        .sys_clk(sys_clk),
        .nrst   (nrst),
        .tick   (tick),
        .din    (cs_s),
        .dout   (cs_f)
    );

    // Edge detection on the filtered mode-select level, reset to the pulled-down level
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cs_prev_reg <= 1'b0;
        end else begin
            cs_prev_reg <= cs_f;
        end
    end

    // Edge detection on idle-high pins, preset high to match the synchroniser reset
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            wake_prev_reg <= 1'b1;
            txd_prev_reg  <= 1'b1;
            bus_prev_reg  <= 1'b1;
        end else begin
            wake_prev_reg <= wake_s;
            txd_prev_reg  <= txd_s;
            bus_prev_reg  <= bus_s;
        end
    end
    assign cs_fall   = cs_prev_reg & ~cs_f;
    assign wake_fall = wake_prev_reg & ~wake_s;
    assign txd_rise  = ~txd_prev_reg & txd_s;
    assign bus_rise  = ~bus_prev_reg & bus_s;

    // Bus low duration qualifier for remote wake
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            wake_cnt_reg  <= 16'h0000;
            wake_long_reg <= 1'b0;
        end else if (bus_s) begin
            wake_cnt_reg <= 16'h0000;
            if (bus_rise) begin
                wake_long_reg <= 1'b0;
            end
        end else if (tick && !wake_long_reg) begin
            if (wake_cnt_reg >= 16'(WAKE_LOW - 1)) begin
                wake_long_reg <= 1'b1;
            end else begin
                wake_cnt_reg <= wake_cnt_reg + 16'h0001;
            end
        end
    end

    // Transmit dominant timeout, cleared on transmit rising edge
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            txd_dom_cnt_reg <= 16'h0000;
            txd_to_reg      <= 1'b0;
        end else if (txd_s) begin
            txd_dom_cnt_reg <= 16'h0000;
            if (txd_rise) begin
                txd_to_reg <= 1'b0;
            end
        end else if (tick && !txd_to_reg) begin
            if (txd_dom_cnt_reg >= 16'(DOM_TIMEOUT - 1)) begin
                txd_to_reg <= 1'b1;
            end else begin
                txd_dom_cnt_reg <= txd_dom_cnt_reg + 16'h0001;
            end
        end
    end

    // Bus dominant timeout, cleared on recessive bus
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            bus_dom_cnt_reg <= 16'h0000;
            bus_to_reg      <= 1'b0;
        end else if (bus_s) begin
            bus_dom_cnt_reg <= 16'h0000;
            bus_to_reg      <= 1'b0;
        end else if (tick && !bus_to_reg) begin
            if (bus_dom_cnt_reg >= 16'(DOM_TIMEOUT - 1)) begin
                bus_to_reg <= 1'b1;
            end else begin
                bus_dom_cnt_reg <= bus_dom_cnt_reg + 16'h0001;
            end
        end
    end

    // Cycles since the receive pull-down let go; the read-back lags by the synchroniser
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rx_rel_cnt_reg <= 2'h0;
        end else if (rxd_oe) begin
            rx_rel_cnt_reg <= 2'h0;
        end else if (rx_rel_cnt_reg != 2'h3) begin
            rx_rel_cnt_reg <= rx_rel_cnt_reg + 2'h1;
        end
    end

    // Receive line monitor: bus recessive must read receive line high
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rx_mon_fault_reg <= 1'b0;
        end else if (mode_reg == lnmc_pkg::LNMC_OPERATION && bus_s && !rxd_oe
                     && rx_rel_cnt_reg == 2'h3 && !rxl_s) begin
            rx_mon_fault_reg <= 1'b1;
        end else if (rxl_s || !bus_s) begin
            rx_mon_fault_reg <= 1'b0;
        end
    end

    // Contention: driving recessive yet bus reads dominant is covered by bus timeout
    assign fault = over_temp | txd_to_reg | bus_to_reg | rx_mon_fault_reg;

    // Mode sequencing
    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            lnmc_pkg::LNMC_POR: begin
                if (supply_ok) begin
                    if (!cs_f) begin
                        mode_next = lnmc_pkg::LNMC_READY;
                    end else if (txd_s && !fault) begin
                        mode_next = lnmc_pkg::LNMC_OPERATION;
                    end else begin
                        mode_next = lnmc_pkg::LNMC_TX_OFF;
                    end
                end
            end
            lnmc_pkg::LNMC_READY: begin
                if (cs_f) begin
                    if (txd_s && !fault) begin
                        mode_next = lnmc_pkg::LNMC_OPERATION;
                    end else begin
                        mode_next = lnmc_pkg::LNMC_TX_OFF;
                    end
                end
            end
            lnmc_pkg::LNMC_OPERATION: begin
                if (cs_fall && txd_s) begin
                    mode_next = lnmc_pkg::LNMC_POWERDOWN;
                end else if (fault || !txd_s && cs_fall) begin
                    mode_next = lnmc_pkg::LNMC_TX_OFF;
                end
            end
            lnmc_pkg::LNMC_TX_OFF: begin
                if (cs_fall || !cs_f) begin
                    mode_next = lnmc_pkg::LNMC_POWERDOWN;
                end else if (txd_s && !fault) begin
                    mode_next = lnmc_pkg::LNMC_OPERATION;
                end
            end
            lnmc_pkg::LNMC_POWERDOWN: begin
                if (supply_ok && (cs_f || wake_fall || (bus_rise && wake_long_reg))) begin
                    mode_next = lnmc_pkg::LNMC_READY;
                end
            end
            default: begin
                mode_next = lnmc_pkg::LNMC_POR;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            mode_reg <= lnmc_pkg::LNMC_POR;
        end else begin
            mode_reg <= mode_next;
        end
    end

    assign tx_active = (mode_next == lnmc_pkg::LNMC_OPERATION);

    // Open-drain data levels stay low; only the enables move
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            bus_out <= 1'b0;
            rxd_out <= 1'b0;
        end else begin
            bus_out <= 1'b0;
            rxd_out <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            bus_oe <= 1'b0;
        end else begin
            bus_oe <= tx_active & ~txd_s;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rxd_oe <= 1'b0;
        end else begin
            rxd_oe <= ~bus_s & mode_powered(mode_next);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            strong_bus_pullup <= 1'b0;
        end else begin
            strong_bus_pullup <= tx_active;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            regulator_enable_out <= 1'b0;
        end else begin
            regulator_enable_out <= mode_powered(mode_next);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            transmitter_off_state <= 1'b0;
        end else begin
            transmitter_off_state <= (mode_next == lnmc_pkg::LNMC_TX_OFF);
        end
    end
endmodule : lnmc_top

// [lnmc_props.sv]
`timescale 1ns/100ps
module lnmc_props (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic supply_ok,
    input wire logic over_temp,
    input wire logic chip_select,
    input wire logic wake_n,
    input wire logic txd,
    input wire logic bus_in,
    input wire logic rxd_line,
    input wire logic bus_out,
    input wire logic bus_oe,
    input wire logic rxd_out,
    input wire logic rxd_oe,
    input wire logic strong_bus_pullup,
    input wire logic regulator_enable_out,
    input wire logic transmitter_off_state
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    sequence tx_low_run;
        (strong_bus_pullup && !txd) [*4];
    endsequence
    sequence bus_dom_run;
        (regulator_enable_out && !bus_in) [*4];
    endsequence
    chk_pullup_op_only: assert property (strong_bus_pullup |-> regulator_enable_out
        && !transmitter_off_state) else $error("pull-up outside operation");
    chk_off_keeps_reg: assert property (transmitter_off_state |-> regulator_enable_out)
        else $error("regulator off in transmitter off");
    chk_pd_all_quiet: assert property (!regulator_enable_out |-> !rxd_oe && !bus_oe
        && !strong_bus_pullup) else $error("activity while powered down");
    chk_tx_drives: assert property (tx_low_run |-> bus_oe)
        else $error("bus not dominant on low transmit");
    chk_tx_release: assert property (txd [*4] |-> !bus_oe)
        else $error("bus dominant on high transmit");
    chk_rx_mirror: assert property (bus_dom_run |-> rxd_oe)
        else $error("receive output not low on dominant bus");
    chk_rx_idle: assert property (bus_in [*4] |-> !rxd_oe)
        else $error("receive output low on recessive bus");
    chk_temp_off: assert property (over_temp [*3] |-> !strong_bus_pullup && !bus_oe)
        else $error("transmitter on during overload");
    chk_op_exit: assert property ($fell(strong_bus_pullup) |-> transmitter_off_state
        || !regulator_enable_out) else $error("operation left to wrong mode");
endmodule : lnmc_props
bind lnmc_top lnmc_props u_props (.sys_clk(sys_clk), .nrst(nrst), .supply_ok(supply_ok),
    .over_temp(over_temp), .chip_select(chip_select), .wake_n(wake_n), .txd(txd),
    .bus_in(bus_in), .rxd_line(rxd_line), .bus_out(bus_out), .bus_oe(bus_oe),
    .rxd_out(rxd_out), .rxd_oe(rxd_oe), .strong_bus_pullup(strong_bus_pullup),
    .regulator_enable_out(regulator_enable_out),
    .transmitter_off_state(transmitter_off_state));

// [lnmc_bus_model.sv]
`timescale 1ns/100ps
module lnmc_bus_model (
    input  wire logic bus_out,
    input  wire logic bus_oe,
    input  wire logic rxd_oe,
    input  wire logic ext_dom,
    input  wire logic rxd_pullup,
    output logic      bus_in,
    output logic      rxd_line
);
    // Weak pull-up holds the wire recessive unless a node pulls it low
    assign bus_in   = !((bus_oe && !bus_out) || ext_dom);
    // Host pull-up on the receive pin; an open pin reads low
    assign rxd_line = rxd_pullup && !rxd_oe;
endmodule : lnmc_bus_model

// [lnmc_top_test.sv]
`timescale 1ns/100ps
module lnmc_top_test;
    localparam logic [2:0] OP   = 3'h6;
    localparam logic [2:0] RDY  = 3'h2;
    localparam logic [2:0] TX_OFF = 3'h3;
    localparam logic [2:0] PD   = 3'h0;
    logic sys_clk     = 1'b0;
    logic nrst        = 1'b0;
    logic supply_ok   = 1'b0;
    logic over_temp   = 1'b0;
    logic chip_select = 1'b0;
    logic wake_n      = 1'b1;
    logic txd         = 1'b1;
    logic ext_dom     = 1'b0;
    logic rxd_pullup  = 1'b1;
    logic bus_in, rxd_line, bus_out, bus_oe, rxd_out, rxd_oe;
    logic strong_bus_pullup, regulator_enable_out, transmitter_off_state;
    int   error_cnt   = 0;
    int   n_compared  = 0;
    always #2.5 sys_clk = ~sys_clk;
    lnmc_top #(.TICK_CYC(2), .DOM_TIMEOUT(50)) DUT (.sys_clk(sys_clk), .nrst(nrst),
        .supply_ok(supply_ok), .over_temp(over_temp), .chip_select(chip_select),
        .wake_n(wake_n), .txd(txd), .bus_in(bus_in), .rxd_line(rxd_line),
        .bus_out(bus_out), .bus_oe(bus_oe), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
        .strong_bus_pullup(strong_bus_pullup), .regulator_enable_out(regulator_enable_out),
        .transmitter_off_state(transmitter_off_state));
    lnmc_bus_model MDL (.bus_out(bus_out), .bus_oe(bus_oe), .rxd_oe(rxd_oe),
        .ext_dom(ext_dom), .rxd_pullup(rxd_pullup), .bus_in(bus_in), .rxd_line(rxd_line));
    task automatic close_out;
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out
    task automatic chk(input logic [2:0] seen, input logic [2:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : wt
    function automatic logic [2:0] mode_v();
        return {strong_bus_pullup, regulator_enable_out, transmitter_off_state};
    endfunction : mode_v
    task automatic s_power_on;
        wt(6);
        chk(mode_v(), PD);
        supply_ok = 1'b1;
        ext_dom = 1'b1;
        txd = 1'b0;
        wt(10);
        chk(mode_v(), RDY);
        chk({2'h0, bus_oe}, 3'h0);
        chk({2'h0, rxd_oe}, 3'h1);
        ext_dom = 1'b0;
        txd = 1'b1;
        chip_select = 1'b1;
        wt(5);
        chip_select = 1'b0;
        wt(40);
        chk(mode_v(), RDY);
        chip_select = 1'b1;
        wt(40);
        chk(mode_v(), OP);
        txd = 1'b0;
        wt(6);
        chk({2'h0, bus_oe}, 3'h1);
        chk({1'b0, bus_out, rxd_out}, 3'h0);
        txd = 1'b1;
        wt(6);
        chk({2'h0, bus_oe}, 3'h0);
    endtask : s_power_on
    task automatic s_faults;
        for (int k = 0; k < 3; k++) begin
            case (k)
                0: rxd_pullup = 1'b0;
                1: over_temp = 1'b1;
                default: ext_dom = 1'b1;
            endcase
            wt(k == 2 ? 130 : 8);
            chk(mode_v(), TX_OFF);
            rxd_pullup = 1'b1;
            over_temp = 1'b0;
            ext_dom = 1'b0;
            wt(10);
            chk(mode_v(), OP);
        end
    endtask : s_faults
    task automatic s_tx_timeout;
        txd = 1'b0;
        wt(60);
        chk(mode_v(), OP);
        wt(70);
        chk(mode_v(), TX_OFF);
        chk({2'h0, bus_oe}, 3'h0);
        txd = 1'b1;
        wt(10);
        chk(mode_v(), OP);
    endtask : s_tx_timeout
    task automatic go_pd;
        chip_select = 1'b1;
        wt(40);
        chip_select = 1'b0;
        wt(40);
        chk(mode_v(), PD);
    endtask : go_pd
    task automatic s_wakes;
        go_pd();
        ext_dom = 1'b1;
        wt(40);
        chk({2'h0, rxd_oe}, 3'h0);
        ext_dom = 1'b0;
        wt(10);
        chk(mode_v(), PD);
        ext_dom = 1'b1;
        wt(170);
        ext_dom = 1'b0;
        wt(10);
        chk(mode_v(), RDY);
        go_pd();
        wake_n = 1'b0;
        wt(10);
        chk(mode_v(), RDY);
        wake_n = 1'b1;
        go_pd();
        txd = 1'b0;
        chip_select = 1'b1;
        wt(40);
        chk(mode_v(), TX_OFF);
        txd = 1'b1;
        wt(10);
        chk(mode_v(), OP);
    endtask : s_wakes
    task automatic s_por_cs_high;
        nrst = 1'b0;
        supply_ok = 1'b0;
        txd = 1'b0;
        wt(3);
        nrst = 1'b1;
        wt(40);
        supply_ok = 1'b1;
        wt(10);
        chk(mode_v(), TX_OFF);
        txd = 1'b1;
        wt(10);
        chk(mode_v(), OP);
    endtask : s_por_cs_high
    initial begin
        #(20000 * 5);
        error_cnt++;
        close_out();
    end
    initial begin
        wt(3);
        nrst = 1'b1;
        s_power_on();
        s_faults();
        s_tx_timeout();
        s_wakes();
        s_por_cs_high();
        close_out();
    end
endmodule : lnmc_top_test
